// file: pps_regs.vh
// constants for the pump program sequencer: register offsets, fields,
// reset values and encodings; included by the sequencer, the checker and the testbench
`ifndef PPS_REGS_VH
`define PPS_REGS_VH
// register offsets (byte addresses)
`define PPS_CTRL        8'h00
`define PPS_CONFIG      8'h04
`define PPS_NET         8'h08
`define PPS_STATUS      8'h0c
`define PPS_EDIT_PHASE  8'h10
`define PPS_PHASE_DATA  8'h14
`define PPS_KEY         8'h18
`define PPS_RESET_ALL   8'h1c
// config fields
`define PPS_CFG_MOTOR_OUT 0
`define PPS_CFG_LOCKOUT   1
`define PPS_CFG_BEEP      2
// net fields
`define PPS_NET_ADDR_LSB  0
`define PPS_NET_BAUD_LSB  8
`define PPS_NET_MODE_LSB  12
// network modes
`define PPS_MODE_ADDRESS  2'h0
`define PPS_MODE_OPPOSITE 2'h1
`define PPS_MODE_SAME     2'h2
`define PPS_MODE_ALTERN   2'h3
// baud codes: 300, 1200, 2400, 9600, 19200
`define PPS_BAUD_MAX      3'h4
`define PPS_BAUD_19200    3'h4
// phase functions
`define PPS_FN_RATE       3'h0
`define PPS_FN_STOP       3'h1
`define PPS_FN_JUMP       3'h2
`define PPS_FN_PAUSE      3'h3
`define PPS_FN_SUBSEL     3'h4
// control bits
`define PPS_CTRL_START    0
`define PPS_CTRL_STOP     1
`define PPS_CTRL_DONE     2
`define PPS_CTRL_SUBGO    3
// key codes from keypad interface
`define PPS_KEY_STARTSTOP 2'h0
`define PPS_KEY_REVIEW    2'h1
`define PPS_KEY_CHANGE    2'h2
// limits, reset value and beep length
`define PPS_MAX_PHASE     6'h29
`define PPS_ADDR_RESET    7'h00
`define PPS_ADDR_MAX      7'h63
`define PPS_BEEP_CYCLES   16'h9c40
`endif

// file: pps_sequencer.v
// pump program sequencer: phase stepping, motor-activity line, keypad
// lockout, buzzer and serial network role control.
// assumes one 20 mhz clock, register port driven synchronously, keypad
// presses decoded outside into one-cycle pulses with a class code.
//
// Rules of the document
// RL1: setting 0: output high only while pumping
// RL2: setting 1: high while pumping or pausing
// RL3: locked without key: only start/stop, review
// RL4: serial link changes ignore keypad lockout
// RL5: grounded detect input means key present
// RL6: blocked keypad change shows refusal, unchanged
// RL7: locked with phase1 subselect autostarts at power
// RL8: system reset clears lockout setting
// RL9: beep continuous at end/wait, single per key
// RL10: network address 00 to 99, default 00
// RL11: selectable rate among five, shared network
// RL12: opposite-direction follower sends start, rate, reversed
// RL13: same-direction follower sends start, rate, same
// RL14: alternating mode starts second pump at stop
// RL15: secondary stays address 0, 19200 baud
// RL16: every start begins at phase 1
// RL17: next phase follows unless function redirects
// RL18: one function per phase, rate and direction
// RL19: non-continuous program ends with stop phase
// RL20: edited phase index saturates at 41
// RL21: phase sequence kept in retained storage
// RL22: running past last phase stops program
`timescale 1ns/1ps
`default_nettype none
`include "pps_regs.vh"
module pps_sequencer #(
  parameter PHASES = 41,
  parameter RATE_W = 16
) (
  // clock and reset
  input  wire              clk,
  input  wire              rst,
  // register port
  input  wire [7:0]        addr,
  input  wire [31:0]       wdata,
  input  wire              wr,
  input  wire              rd,
  output reg  [31:0]       rdata,
  // keypad and sensing
  input  wire              key_press,
  input  wire [1:0]        key_class,
  input  wire              program_detect_n,
  // motor interface
  input  wire              phase_done,
  output reg               motor_run,
  output reg               motor_dir,
  output reg  [RATE_W-1:0] motor_rate,
  output reg               motor_active,
  output reg               buzzer,
  output reg               refuse_msg,
  output reg               subsel_prompt,
  // secondary pump commands
  output reg               sec_run,
  output reg               sec_dir,
  output reg  [RATE_W-1:0] sec_rate
);
  // ------------------------------------------------------------
  // state and storage
  // ------------------------------------------------------------
  localparam ST_IDLE  = 2'h0;
  localparam ST_RUN   = 2'h1;
  localparam ST_PAUSE = 2'h2;
  localparam ST_WAIT  = 2'h3;
  // phase word: [2:0] function, [3] direction, [9:4] target,
  // [31:16] rate; retained array, no reset so contents survive
  reg [31:0]       phase_mem [1:PHASES];  // see RL21 see RL18
  reg [1:0]        state;
  reg [5:0]        phase;
  reg [5:0]        edit_phase;
  reg              motor_cfg;
  reg              lockout;
  reg              beep_en;
  reg [6:0]        net_addr;
  reg [2:0]        baud;
  reg [1:0]        net_mode;
  reg              power_up;
  reg [15:0]       beep_cnt;
  reg              prev_running;
  reg [1:0]        next_state;
  reg [5:0]        next_phase;
  wire             key_present = ~program_detect_n;  // see RL5
  wire             kp_block = lockout & ~key_present;
  wire             kp_change = key_press &
                               (key_class == `PPS_KEY_CHANGE);
  wire             kp_start = key_press &
                              (key_class == `PPS_KEY_STARTSTOP);
  wire [31:0]      cur = phase_mem[phase];
  wire [2:0]       cur_fn = cur[2:0];
  wire             wr_ctrl = wr & (addr == `PPS_CTRL);
  wire             sw_start = wr_ctrl & wdata[`PPS_CTRL_START];
  wire             sw_stop = wr_ctrl & wdata[`PPS_CTRL_STOP];
  wire             running = (state != ST_IDLE);
  // write decodes; wr_cfg and wr_wipe are each shared by two processes below
  wire             wr_cfg = wr & (addr == `PPS_CONFIG);
  wire             wr_net = wr & (addr == `PPS_NET);
  wire             wr_edit = wr & (addr == `PPS_EDIT_PHASE);
  wire             wr_data = wr & (addr == `PPS_PHASE_DATA);
  wire             wr_wipe = wr & (addr == `PPS_RESET_ALL);
  // advance one phase, stopping past the last one
  function [5:0] pps_next;
    input [5:0] p;
    begin
      if (p >= PHASES[5:0])
        pps_next = 6'h00;
      else
        pps_next = p + 6'h01;
    end
  endfunction
  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always @* begin
    next_state = state;
    next_phase = phase;
    if (sw_stop || (kp_start && running)) begin
      next_state = ST_IDLE;
    end else if (sw_start || (kp_start && !running)) begin
      next_state = ST_RUN;
      next_phase = 6'h01;  // see RL16
    end else if (running) begin
      case (cur_fn)
        `PPS_FN_STOP: next_state = ST_IDLE;
        `PPS_FN_JUMP: next_phase = cur[9:4];  // see RL17
        `PPS_FN_SUBSEL: begin
          next_state = ST_WAIT;
          if (wr_ctrl && wdata[`PPS_CTRL_SUBGO]) begin
            next_state = ST_RUN;
            next_phase = wdata[9:4];
          end
        end
        default: begin
          next_state = (cur_fn == `PPS_FN_PAUSE) ? ST_PAUSE : ST_RUN;
          if (phase_done ||
              (wr_ctrl && wdata[`PPS_CTRL_DONE])) begin
            next_phase = pps_next(phase);  // see RL17
            if (pps_next(phase) == 6'h00)
              next_state = ST_IDLE;  // see RL22
          end
        end
      endcase
      if (next_phase == 6'h00 || next_phase > PHASES[5:0]) begin
        next_state = ST_IDLE;
        next_phase = 6'h01;
      end
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      phase <= 6'h01;
      power_up <= 1'b1;
    end else begin
      power_up <= 1'b0;
      if (power_up && lockout &&
          phase_mem[1][2:0] == `PPS_FN_SUBSEL) begin
        state <= ST_WAIT;  // see RL7
        phase <= 6'h01;
      end else begin
        state <= next_state;
        phase <= next_phase;
      end
    end
  end
  // ------------------------------------------------------------
  // registers written by software and keypad
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (wr_data && edit_phase != 6'h00)
      phase_mem[edit_phase] <= wdata;  // see RL4
  end
  // lockout sits in retained storage beside the program: a power-on
  // reset must not clear it, or the auto-run start could never occur
  always @(posedge clk) begin
    if (wr_wipe)
      lockout <= 1'b0;  // see RL8
    else if (wr_cfg && key_present)
      lockout <= wdata[`PPS_CFG_LOCKOUT];  // see RL5
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      motor_cfg <= 1'b0;
      beep_en <= 1'b0;
      net_addr <= `PPS_ADDR_RESET;
      baud <= `PPS_BAUD_19200;
      net_mode <= `PPS_MODE_ADDRESS;
      refuse_msg <= 1'b0;
    end else begin
      if (key_press)
        refuse_msg <= kp_change & kp_block;  // see RL6 see RL3
      if (wr_wipe) begin
        net_addr <= `PPS_ADDR_RESET;
        net_mode <= `PPS_MODE_ADDRESS;
      end else if (wr_cfg) begin
        motor_cfg <= wdata[`PPS_CFG_MOTOR_OUT];
        beep_en <= wdata[`PPS_CFG_BEEP];
      end else if (wr_net) begin
        // out-of-range fields are dropped, the others still land
        if (wdata[6:0] <= `PPS_ADDR_MAX)
          net_addr <= wdata[6:0];  // see RL10
        if (wdata[10:8] <= `PPS_BAUD_MAX)
          baud <= wdata[10:8];  // see RL11
        net_mode <= wdata[13:12];
      end
    end
  end
  // ------------------------------------------------------------
  // edit pointer
  // ------------------------------------------------------------
  // software and keypad share the pointer; a bus write wins a tie
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      edit_phase <= 6'h01;
    end else if (wr_edit) begin
      if (wdata[5:0] > `PPS_MAX_PHASE || wdata[31:6] != 26'h0)
        edit_phase <= `PPS_MAX_PHASE;  // see RL20
      else
        edit_phase <= wdata[5:0];
    end else if (kp_change && !kp_block) begin
      if (edit_phase >= `PPS_MAX_PHASE)
        edit_phase <= `PPS_MAX_PHASE;  // see RL20
      else
        edit_phase <= edit_phase + 6'h01;
    end
  end
  // ------------------------------------------------------------
  // outputs: motor lines and subselect prompt
  // ------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      motor_run <= 1'b0;
      motor_dir <= 1'b0;
      motor_rate <= {RATE_W{1'b0}};
      motor_active <= 1'b0;
      subsel_prompt <= 1'b0;
    end else begin
      motor_run <= (state == ST_RUN) && (cur_fn == `PPS_FN_RATE);
      motor_dir <= cur[3];
      motor_rate <= cur[31:32-RATE_W];
      if (motor_cfg)
        motor_active <= (state == ST_RUN) ||
                        (state == ST_PAUSE);  // see RL2
      else
        motor_active <= (state == ST_RUN) &&
                        (cur_fn == `PPS_FN_RATE);  // see RL1
      subsel_prompt <= (state == ST_WAIT);  // see RL7
    end
  end
  // ------------------------------------------------------------
  // buzzer
  // ------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      buzzer <= 1'b0;
      beep_cnt <= 16'h0000;
    end else begin
      // single beep lasts a fixed count; end/wait beeps steadily
      if (key_press)
        beep_cnt <= `PPS_BEEP_CYCLES;
      else if (beep_cnt != 16'h0000)
        beep_cnt <= beep_cnt - 16'h0001;
      buzzer <= beep_en & (state == ST_WAIT || state == ST_IDLE ||
                           beep_cnt != 16'h0000);  // see RL9
    end
  end
  // ------------------------------------------------------------
  // secondary pump
  // ------------------------------------------------------------
  // followers copy the registered motor outputs, so they trail the
  // primary by one clock, far below one character on the link
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_running <= 1'b0;
      sec_run <= 1'b0;
      sec_dir <= 1'b0;
      sec_rate <= {RATE_W{1'b0}};
    end else begin
      prev_running <= running;
      case (net_mode)
        `PPS_MODE_OPPOSITE: begin
          sec_run <= motor_run;  // see RL12
          sec_dir <= ~motor_dir;
          sec_rate <= motor_rate;
        end
        `PPS_MODE_SAME: begin
          sec_run <= motor_run;  // see RL13
          sec_dir <= motor_dir;
          sec_rate <= motor_rate;
        end
        `PPS_MODE_ALTERN: begin
          // in either setting, a pause keeps the hand-off back
          if (prev_running && !running)
            sec_run <= 1'b1;  // see RL14
          else if (running)
            sec_run <= 1'b0;
        end
        default: sec_run <= 1'b0;
      endcase
    end
  end
  // ------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst)
      rdata <= 32'h0000_0000;
    else if (rd) begin
      case (addr)
        `PPS_CONFIG:
          rdata <= {29'h0, beep_en, lockout & key_present, motor_cfg};
        `PPS_NET:
          rdata <= {18'h0, net_mode, 1'b0, baud, 1'b0, net_addr};
        `PPS_STATUS:
          rdata <= {22'h0, refuse_msg, key_present, state, phase};
        `PPS_EDIT_PHASE: rdata <= {26'h0, edit_phase};
        `PPS_PHASE_DATA: rdata <= phase_mem[edit_phase];
        default: rdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: pps_seq_chk.sv
// port checker for the pump program sequencer
// assumes bound onto every pps_sequencer, register port at offsets below
`timescale 1ns/1ps
`default_nettype none
`include "pps_regs.vh"
module pps_seq_chk #(
  parameter RATE_W = 16
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // register port
  input wire logic [7:0]        addr,
  input wire logic [31:0]       wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [31:0]       rdata,
  // keypad and motor
  input wire logic              key_press,
  input wire logic [1:0]        key_class,
  input wire logic              program_detect_n,
  input wire logic              motor_run,
  input wire logic              motor_active,
  input wire logic              refuse_msg,
  input wire logic [RATE_W-1:0] motor_rate,
  input wire logic              sec_run,
  input wire logic [RATE_W-1:0] sec_rate
);
  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence edit_big;
    wr && addr == `PPS_EDIT_PHASE && wdata > 32'd41;
  endsequence
  sequence edit_rd;
    rd && addr == `PPS_EDIT_PHASE;
  endsequence
  sequence go;
    wr && addr == `PPS_CTRL && wdata[`PPS_CTRL_START];
  endsequence
  sequence st_rd;
    rd && addr == `PPS_STATUS;
  endsequence
  read_hold_a: assert property (!$past(rd) |-> $stable(rdata))
    else $error("read data moved without a read");
  run_active_a: assert property (
    motor_run && $past(motor_run) |-> motor_active)
    else $error("pumping without activity line");
  follow_rate_a: assert property (
    sec_run && motor_run && $stable(motor_rate) |-> sec_rate == motor_rate)
    else $error("secondary rate differs");
  key_ok_a: assert property (
    key_press && !program_detect_n |=> !refuse_msg)
    else $error("refused with key present");
  key_allowed_a: assert property (
    key_press && key_class != `PPS_KEY_CHANGE |=> !refuse_msg)
    else $error("start or review refused");
  unmapped_a: assert property (rd && addr == 8'h20 |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  edit_sat_a: assert property (
    edit_big ##2 edit_rd |=> rdata == 32'h29)
    else $error("edit phase not saturated");
  start_ph1_a: assert property (
    go ##2 st_rd |=> rdata[5:0] == 6'h01)
    else $error("start not at phase one");
endmodule
bind pps_sequencer pps_seq_chk #(.RATE_W(RATE_W)) i_chk (.clk(clk), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .key_press(key_press), .key_class(key_class),
  .program_detect_n(program_detect_n), .motor_run(motor_run),
  .motor_active(motor_active), .refuse_msg(refuse_msg),
  .motor_rate(motor_rate), .sec_run(sec_run), .sec_rate(sec_rate));
`default_nettype wire

// file: pps_motor_model.sv
// motor driver and secondary pump model
// assumes phase_done is sampled by the sequencer on the next rising edge
`timescale 1ns/1ps
`default_nettype none
module pps_motor_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic motor_run,
  input  wire logic stall,
  output var  logic phase_done
);
  // secondary pump stays at its defaults while it follows
  localparam logic [6:0] SEC_ADDR = 7'h00;
  localparam logic [2:0] SEC_BAUD = 3'h4;
  logic [3:0] cnt;
  // stall lets the bench hold a phase open as long as it likes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      phase_done <= 1'b0;
    end else begin
      phase_done <= 1'b0;
      if (motor_run && !stall) begin
        cnt <= cnt + 4'h1;
        if (cnt == 4'h7) begin
          phase_done <= 1'b1;
        end
      end else begin
        cnt <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// file: pps_sequencer_tb_top.sv
// testbench for the pump program sequencer
// assumes the 20 mhz clock and the register map of pps_regs.vh
`timescale 1ns/1ps
`default_nettype none
`include "pps_regs.vh"
module pps_sequencer_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        key_press = 1'b0;
  logic [1:0]  key_class = 2'h0;
  logic        detect_n = 1'b0;
  logic        stall = 1'b1;
  logic [31:0] d;
  wire         phase_done, motor_run, motor_dir, motor_active, buzzer;
  wire         refuse_msg, subsel_prompt, sec_run, sec_dir;
  wire  [31:0] rdata;
  wire  [15:0] motor_rate, sec_rate;
  int          failures = 0;
  int          n_checks = 0;
  always #25 clk = ~clk;
  pps_sequencer i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .key_press(key_press),
    .key_class(key_class), .program_detect_n(detect_n),
    .phase_done(phase_done), .motor_run(motor_run), .motor_dir(motor_dir),
    .motor_rate(motor_rate), .motor_active(motor_active), .buzzer(buzzer),
    .refuse_msg(refuse_msg), .subsel_prompt(subsel_prompt),
    .sec_run(sec_run), .sec_dir(sec_dir), .sec_rate(sec_rate));
  pps_motor_model i_motor (.clk(clk), .rst(rst), .motor_run(motor_run),
    .stall(stall), .phase_done(phase_done));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic prog(input logic [7:0] n, input logic [31:0] w);
    wreg(`PPS_EDIT_PHASE, {24'h0, n});
    wreg(`PPS_PHASE_DATA, w);
  endtask
  task automatic key(input logic [1:0] c);
    @(posedge clk);
    key_press <= 1'b1;
    key_class <= c;
    @(posedge clk);
    key_press <= 1'b0;
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // waits under a bound for the motor model to end the phase
  task automatic wait_done;
    int i;
    i = 0;
    stall <= 1'b0;
    while (phase_done !== 1'b1 && i < 40) begin
      @(posedge clk);
      #1 i++;
    end
    if (i == 40) failures++;
    @(posedge clk);
    #1 stall <= 1'b1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #2000000 failures++;
    report_and_stop();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rreg(`PPS_NET);
    chk(d, 32'h400);
    wreg(`PPS_EDIT_PHASE, 32'd50);
    rreg(`PPS_EDIT_PHASE);
    chk(d, 32'h29);
    rreg(8'h20);
    chk(d, 32'h0);
    prog(8'h1, 32'h1234_0008);
    prog(8'h2, 32'h3);
    prog(8'h3, 32'h1);
    wreg(`PPS_CONFIG, 32'h4);
    wreg(`PPS_CTRL, 32'h1);
    rreg(`PPS_STATUS);
    chk(d, 32'h141);
    chk({motor_run, motor_dir, motor_active, motor_rate}, 19'h7_1234);
    wait_done();
    rreg(`PPS_STATUS);
    chk({motor_run, motor_active, d[9:0]}, 12'h182);
    wreg(`PPS_CTRL, 32'h4);
    rreg(`PPS_STATUS);
    chk({buzzer, motor_active, d[7:6]}, 4'h8);
    wreg(`PPS_CONFIG, 32'h5);
    wreg(`PPS_CTRL, 32'h1);
    wait_done();
    repeat (2) @(posedge clk);
    #1 chk({motor_run, motor_active, buzzer}, 3'h2);
    key(`PPS_KEY_REVIEW);
    @(posedge clk);
    #1 chk(buzzer, 1'b1);
    wreg(`PPS_CTRL, 32'h2);
    rreg(`PPS_STATUS);
    chk({motor_active, d[7:6]}, 3'h0);
    wreg(`PPS_NET, 32'h463);
    wreg(`PPS_NET, 32'h464);
    wreg(`PPS_NET, 32'h563);
    rreg(`PPS_NET);
    chk(d, 32'h463);
    wreg(`PPS_CONFIG, 32'h4);
    for (int m = 1; m < 4; m++) begin
      wreg(`PPS_NET, {18'h0, m[1:0], 12'h400});
      wreg(`PPS_CTRL, 32'h1);
      rreg(`PPS_STATUS);
      if (m < 3) chk({sec_run, sec_dir ^ motor_dir, sec_rate}, {1'b1, m == 1, 16'h1234});
      wreg(`PPS_CTRL, 32'h2);
      rreg(`PPS_STATUS);
      if (m == 3) chk(sec_run, 1'b1);
    end
    wreg(`PPS_NET, 32'h400);
    wreg(`PPS_CONFIG, 32'h2);
    rreg(`PPS_CONFIG);
    chk(d, 32'h2);
    @(posedge clk) detect_n <= 1'b1;
    rreg(`PPS_CONFIG);
    chk(d, 32'h0);
    wreg(`PPS_EDIT_PHASE, 32'h5);
    key(`PPS_KEY_CHANGE);
    rreg(`PPS_STATUS);
    chk({refuse_msg, d[9]}, 2'h3);
    rreg(`PPS_EDIT_PHASE);
    chk(d, 32'h5);
    key(`PPS_KEY_REVIEW);
    chk(refuse_msg, 1'b0);
    key(`PPS_KEY_STARTSTOP);
    rreg(`PPS_STATUS);
    chk({motor_run, d[7:6]}, 3'h5);
    key(`PPS_KEY_STARTSTOP);
    @(posedge clk) detect_n <= 1'b0;
    key(`PPS_KEY_CHANGE);
    rreg(`PPS_EDIT_PHASE);
    chk({refuse_msg, d[5:0]}, 7'h06);
    prog(8'h1, 32'h4);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rreg(`PPS_STATUS);
    chk({subsel_prompt, d[7:6]}, 3'h7);
    wreg(`PPS_RESET_ALL, 32'h1);
    rreg(`PPS_CONFIG);
    chk(d[1], 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
